/* core/tpp_consts.vh */
/*
 * Constants for the test access port programming block: controller state
 * codes, instruction codes, operation kinds and register widths.
 * Assumes inclusion by bare name from the core design files.
 */
`ifndef TPP_CONSTS_VH
`define TPP_CONSTS_VH

// Controller state codes
`define TPP_ST_RESET      4'h0
`define TPP_ST_IDLE       4'h1
`define TPP_ST_SEL_DR     4'h2
`define TPP_ST_CAP_DR     4'h3
`define TPP_ST_SHIFT_DR   4'h4
`define TPP_ST_EXIT1_DR   4'h5
`define TPP_ST_PAUSE_DR   4'h6
`define TPP_ST_EXIT2_DR   4'h7
`define TPP_ST_UPD_DR     4'h8
`define TPP_ST_SEL_IR     4'h9
`define TPP_ST_CAP_IR     4'hA
`define TPP_ST_SHIFT_IR   4'hB
`define TPP_ST_EXIT1_IR   4'hC
`define TPP_ST_PAUSE_IR   4'hD
`define TPP_ST_EXIT2_IR   4'hE
`define TPP_ST_UPD_IR     4'hF

// Instruction widths and codes
`define TPP_IR_W          8
`define TPP_ID_W          32
`define TPP_CFG_W         32
`define TPP_INS_IDCODE    8'h16
`define TPP_INS_BYPASS    8'hFF
`define TPP_INS_EXTEST    8'h00
`define TPP_INS_SAMPLE    8'h1C
`define TPP_INS_CFG_ADDR  8'h2B
`define TPP_INS_CFG_DATA  8'h2D
`define TPP_INS_CFG_ERASE 8'h29
`define TPP_INS_CFG_PROG  8'h2E
`define TPP_INS_CFG_VER   8'h28
`define TPP_INS_BULK_ERS  8'h03
`define TPP_INS_PLD_PROG  8'h07
`define TPP_INS_PLD_VER   8'h0A
`define TPP_INS_UES_PROG  8'h1A
`define TPP_INS_RESET_DEV 8'h22

// Operation kinds reported at the start of a deferred operation
`define TPP_OP_NONE       2'h0
`define TPP_OP_PROGRAM    2'h1
`define TPP_OP_ERASE      2'h2
`define TPP_OP_VERIFY     2'h3

// Address register width
`define TPP_ADDR_W        8

`endif

/* core/tpp_pin_sync.v */
/*
 * Two-flop synchroniser for the test pins, followed by an edge finder on
 * the synchronised test clock.
 * Assumes pins are asynchronous to sys_clk_i, which is much faster than
 * the test clock.
 */
`timescale 1ns/100ps
module tpp_pin_sync (
	input  wire       sys_clk_i,
	input  wire       reset_n_i,
	input  wire       tck_i,
	input  wire       tms_i,
	input  wire       tdi_i,
	output reg        tms_o,
	output reg        tdi_o,
	output reg        rise_o,
	output reg        fall_o
);
	reg  [2:0] meta_reg;
	reg        tck_reg;
	reg        tck_d_reg;

	// Two-flop stages, then edge detection on the second stage only
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_reg  <= 3'h0;
			tck_reg   <= 1'b0;
			tms_o     <= 1'b1;
			tdi_o     <= 1'b0;
			tck_d_reg <= 1'b0;
			rise_o    <= 1'b0;
			fall_o    <= 1'b0;
		end else begin
			meta_reg  <= {tck_i, tms_i, tdi_i};
			tck_reg   <= meta_reg[2];
			tms_o     <= meta_reg[1];
			tdi_o     <= meta_reg[0];
			tck_d_reg <= tck_reg;
			rise_o    <= tck_reg & ~tck_d_reg;
			fall_o    <= ~tck_reg & tck_d_reg;
		end
	end
endmodule // tpp_pin_sync

/* core/tpp_fsm.v */
/*
 * Sixteen-state test access controller, advanced once per test clock
 * rising edge.
 * Assumes step_i is a one-cycle pulse and tms_i is stable when it comes.
 */
`timescale 1ns/100ps
`include "tpp_consts.vh"
module tpp_fsm (
	input  wire       sys_clk_i,
	input  wire       reset_n_i,
	input  wire       step_i,
	input  wire       tms_i,
	output reg  [3:0] state_o
);
	reg [3:0] state_next;

	// Next state from tms level
	always @* begin
		case (state_o)
		`TPP_ST_RESET:    state_next = tms_i ? `TPP_ST_RESET : `TPP_ST_IDLE;
		`TPP_ST_IDLE:     state_next = tms_i ? `TPP_ST_SEL_DR : `TPP_ST_IDLE;
		`TPP_ST_SEL_DR:   state_next = tms_i ? `TPP_ST_SEL_IR : `TPP_ST_CAP_DR;
		`TPP_ST_CAP_DR:   state_next = tms_i ? `TPP_ST_EXIT1_DR
			: `TPP_ST_SHIFT_DR;
		`TPP_ST_SHIFT_DR: state_next = tms_i ? `TPP_ST_EXIT1_DR
			: `TPP_ST_SHIFT_DR;
		`TPP_ST_EXIT1_DR: state_next = tms_i ? `TPP_ST_UPD_DR
			: `TPP_ST_PAUSE_DR;
		`TPP_ST_PAUSE_DR: state_next = tms_i ? `TPP_ST_EXIT2_DR
			: `TPP_ST_PAUSE_DR;
		`TPP_ST_EXIT2_DR: state_next = tms_i ? `TPP_ST_UPD_DR
			: `TPP_ST_SHIFT_DR;
		`TPP_ST_UPD_DR:   state_next = tms_i ? `TPP_ST_SEL_DR : `TPP_ST_IDLE;
		`TPP_ST_SEL_IR:   state_next = tms_i ? `TPP_ST_RESET : `TPP_ST_CAP_IR;
		`TPP_ST_CAP_IR:   state_next = tms_i ? `TPP_ST_EXIT1_IR
			: `TPP_ST_SHIFT_IR;
		`TPP_ST_SHIFT_IR: state_next = tms_i ? `TPP_ST_EXIT1_IR
			: `TPP_ST_SHIFT_IR;
		`TPP_ST_EXIT1_IR: state_next = tms_i ? `TPP_ST_UPD_IR
			: `TPP_ST_PAUSE_IR;
		`TPP_ST_PAUSE_IR: state_next = tms_i ? `TPP_ST_EXIT2_IR
			: `TPP_ST_PAUSE_IR;
		`TPP_ST_EXIT2_IR: state_next = tms_i ? `TPP_ST_UPD_IR
			: `TPP_ST_SHIFT_IR;
		`TPP_ST_UPD_IR:   state_next = tms_i ? `TPP_ST_SEL_DR : `TPP_ST_IDLE;
		default:          state_next = `TPP_ST_RESET;
		endcase
	end

	// State register, steps only on test clock rise
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			state_o <= `TPP_ST_RESET;
		else if (step_i)
			state_o <= state_next;
	end
endmodule // tpp_fsm

/* core/tpp_top.v */
/*
 * Test access port used as the serial programming port: pin sampling,
 * controller, instruction register, identification, bypass, address and
 * configuration data paths, and dispatch of internal operations.
 * Assumes an external host drives the test clock, mode select and data
 * input, and that sys_clk_i runs at least eight times the test clock.
 */
// How it works
// - Sixteen-state controller steps on each test clock rise by mode select.
// - Data input and mode select are taken at the test clock rising edge.
// - Data output changes on the test clock falling edge.
// - Six states hold: reset, idle, shift and pause of both branches.
// - Mode select high for five clocks reaches reset from anywhere.
// - After power-on the controller sits in reset.
// - Leaving reset goes to idle.
// - Idle does nothing without a pending deferred instruction.
// - Data and instruction branches share one sequence, starting with capture.
// - Capture-DR loads the selected data register into the shift path.
// - Capture-IR always loads the identification instruction code.
// - Without another instruction the identification register is selected.
// - Capture goes to shift or exit1 by mode select.
// - Shift leaves through exit1, then to update or pause.
// - Pause holds the shift path unchanged.
// - Pause leaves through exit2 back to shift or on to update.
// - Program, erase, verify start on next entry to idle, unless reset comes first; here a pending one starts only when idle is entered from update-DR.
// - Other instructions act in the update state.
// - The updated instruction picks the data path and the operation.
// - Identification instruction is eight bits and selects the id register.
// - All-ones code selects a one-stage bypass register.
// - Thirty-two bit id register readable right after reset.
`timescale 1ns/100ps
`include "tpp_consts.vh"
module tpp_top #(
	parameter [31:0] ID_VALUE = 32'h0A5A5001 // Arbitrary identity value
) (
	input  wire                    sys_clk_i,
	input  wire                    reset_n_i,
	input  wire                    tck_i,
	input  wire                    tms_i,
	input  wire                    tdi_i,
	output reg                     tdo_o,
	output reg                     tdo_oe_o,
	output reg                     op_start_o,
	output reg  [1:0]              op_kind_o,
	output reg  [`TPP_IR_W-1:0]    op_instr_o,
	output reg  [`TPP_ADDR_W-1:0]  cfg_addr_o,
	output reg  [`TPP_CFG_W-1:0]   cfg_data_o,
	output reg                     dev_reset_o,
	output reg                     tlr_o
);
	wire                   tms_s;
	wire                   tdi_s;
	wire                   tck_rise;
	wire                   tck_fall;
	wire [3:0]             state;

	reg  [`TPP_IR_W-1:0]   ir_shift_reg;
	reg  [`TPP_IR_W-1:0]   ir_reg;
	reg  [`TPP_ID_W-1:0]   dr_shift_reg;
	reg                    bypass_reg;
	reg                    pend_reg;
	reg  [1:0]             pend_kind_reg;
	reg  [`TPP_ADDR_W-1:0] addr_reg;
	reg  [`TPP_CFG_W-1:0]  data_reg;
	reg                    serial_out;

	// Classify a deferred operation; other codes act at update
	function [1:0] op_class;
		input [`TPP_IR_W-1:0] code;
		begin
			case (code)
			`TPP_INS_CFG_PROG,
			`TPP_INS_PLD_PROG,
			`TPP_INS_UES_PROG:  op_class = `TPP_OP_PROGRAM;
			`TPP_INS_CFG_ERASE,
			`TPP_INS_BULK_ERS:  op_class = `TPP_OP_ERASE;
			`TPP_INS_CFG_VER,
			`TPP_INS_PLD_VER:   op_class = `TPP_OP_VERIFY;
			default:            op_class = `TPP_OP_NONE;
			endcase
		end
	endfunction

	// Data path selection from current instruction
	function [1:0] dr_sel;
		input [`TPP_IR_W-1:0] code;
		begin
			case (code)
			`TPP_INS_IDCODE:   dr_sel = 2'h1;
			`TPP_INS_CFG_ADDR: dr_sel = 2'h2;
			`TPP_INS_CFG_DATA: dr_sel = 2'h3;
			default:           dr_sel = 2'h0; // bypass, incl. 00 and sample
			endcase
		end
	endfunction

	// Pin sampling into the system clock domain
	tpp_pin_sync u_sync (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.tck_i     (tck_i),
		.tms_i     (tms_i),
		.tdi_i     (tdi_i),
		.tms_o     (tms_s),
		.tdi_o     (tdi_s),
		.rise_o    (tck_rise),
		.fall_o    (tck_fall)
	);

	// Controller
	tpp_fsm u_fsm (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.step_i    (tck_rise),
		.tms_i     (tms_s),
		.state_o   (state)
	);

	// Instruction register and its shift path
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ir_shift_reg <= `TPP_INS_IDCODE;
			ir_reg       <= `TPP_INS_IDCODE;
		end else if (tck_rise) begin
			case (state)
			`TPP_ST_RESET:
				ir_reg <= `TPP_INS_IDCODE;
			`TPP_ST_CAP_IR:
				ir_shift_reg <= `TPP_INS_IDCODE;
			`TPP_ST_SHIFT_IR:
				ir_shift_reg <= {tdi_s, ir_shift_reg[`TPP_IR_W-1:1]};
			`TPP_ST_UPD_IR:
				ir_reg <= ir_shift_reg;
			default:
				ir_shift_reg <= ir_shift_reg;
			endcase
		end
	end

	// Data shift path: capture, shift, update
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dr_shift_reg <= {`TPP_ID_W{1'b0}};
			bypass_reg   <= 1'b0;
			addr_reg     <= {`TPP_ADDR_W{1'b0}};
			data_reg     <= {`TPP_CFG_W{1'b0}};
		end else if (tck_rise) begin
			case (state)
			`TPP_ST_CAP_DR: begin
				bypass_reg <= 1'b0;
				case (dr_sel(ir_reg))
				2'h1: dr_shift_reg <= ID_VALUE;
				2'h2: dr_shift_reg <= {addr_reg,
					{(`TPP_ID_W-`TPP_ADDR_W){1'b0}}}; // Sits at the tap
				2'h3: dr_shift_reg <= data_reg;
				default: dr_shift_reg <= dr_shift_reg;
				endcase
			end
			`TPP_ST_SHIFT_DR: begin
				bypass_reg   <= tdi_s;
				dr_shift_reg <= {tdi_s, dr_shift_reg[`TPP_ID_W-1:1]};
			end
			`TPP_ST_UPD_DR: begin
				// address then data, committed later by program
				if (dr_sel(ir_reg) == 2'h2)
					addr_reg <= dr_shift_reg[`TPP_ID_W-1:
						`TPP_ID_W-`TPP_ADDR_W];
				if (dr_sel(ir_reg) == 2'h3)
					data_reg <= dr_shift_reg;
			end
			default: bypass_reg <= bypass_reg;
			endcase
		end
	end

	// Address shift is narrower: its bits arrive at the top of the path
	// Serial output source chosen by branch and instruction
	always @* begin
		if (state == `TPP_ST_SHIFT_IR)
			serial_out = ir_shift_reg[0];
		else if (dr_sel(ir_reg) == 2'h0)
			serial_out = bypass_reg;
		else if (dr_sel(ir_reg) == 2'h2)
			serial_out = dr_shift_reg[`TPP_ID_W-`TPP_ADDR_W];
		else
			serial_out = dr_shift_reg[0];
	end

	// Output pin updated on test clock fall, driven only while shifting
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tdo_o    <= 1'b1;
			tdo_oe_o <= 1'b0;
		end else if (tck_fall) begin
			tdo_o    <= serial_out;
			tdo_oe_o <= (state == `TPP_ST_SHIFT_DR) ||
				(state == `TPP_ST_SHIFT_IR);
		end
	end

	// Deferred operations and update-time instructions
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pend_reg      <= 1'b0;
			pend_kind_reg <= `TPP_OP_NONE;
			op_start_o    <= 1'b0;
			op_kind_o     <= `TPP_OP_NONE;
			op_instr_o    <= `TPP_INS_IDCODE;
			dev_reset_o   <= 1'b0;
			tlr_o         <= 1'b1;
			cfg_addr_o    <= {`TPP_ADDR_W{1'b0}};
			cfg_data_o    <= {`TPP_CFG_W{1'b0}};
		end else begin
			op_start_o  <= 1'b0;
			dev_reset_o <= 1'b0;
			cfg_addr_o  <= addr_reg;
			cfg_data_o  <= data_reg;
			if (tck_rise) begin
				tlr_o <= (state == `TPP_ST_RESET);
				if (state == `TPP_ST_RESET)
					pend_reg <= 1'b0;
				else if (state == `TPP_ST_UPD_IR) begin
					pend_kind_reg <= op_class(ir_shift_reg);
					// Kept only when idle is not entered straight away
					pend_reg <= (op_class(ir_shift_reg) != `TPP_OP_NONE) &&
						tms_s;
					if (ir_shift_reg == `TPP_INS_RESET_DEV)
						dev_reset_o <= 1'b1;
					// update straight into idle starts the new code
					if (!tms_s &&
						(op_class(ir_shift_reg) != `TPP_OP_NONE)) begin
						op_start_o <= 1'b1;
						op_kind_o  <= op_class(ir_shift_reg);
						op_instr_o <= ir_shift_reg;
					end
				end
				// entering idle from update-DR with a pending operation starts it
				if (pend_reg && !tms_s &&
					(state == `TPP_ST_UPD_DR)) begin
					pend_reg   <= 1'b0;
					op_start_o <= 1'b1;
					op_kind_o  <= pend_kind_reg;
					op_instr_o <= ir_reg;
				end
			end
		end
	end
endmodule // tpp_top

/* bench/tpp_top_monitor.sv */
/* Pin-level checker for tpp_top.
 * Assumes sys_clk_i runs far faster than tck_i. */
`timescale 1ns/100ps
`include "tpp_consts.vh"
module tpp_top_monitor (
	input wire                  sys_clk_i,
	input wire                  reset_n_i,
	input wire                  tck_i,
	input wire                  tms_i,
	input wire                  tdo_o,
	input wire                  tdo_oe_o,
	input wire                  op_start_o,
	input wire [1:0]            op_kind_o,
	input wire [`TPP_CFG_W-1:0] cfg_data_o,
	input wire                  dev_reset_o,
	input wire                  tlr_o
);
	reg [2:0] hi_cnt_reg; // Test clock rises with mode select high
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Count rises seen with mode select high, saturating at 7
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			hi_cnt_reg <= 3'h0;
		else if ($rose(tck_i))
			hi_cnt_reg <= tms_i ? hi_cnt_reg + {2'h0, hi_cnt_reg != 3'h7} : 3'h0;
	end
	// Pulses are one cycle wide
	sequence start_pulse;
		op_start_o ##1 !op_start_o;
	endsequence
	sequence reset_pulse;
		dev_reset_o ##1 !dev_reset_o;
	endsequence
	start_one_a: assert property (op_start_o |-> start_pulse)
		else $error("operation start wider than one cycle");
	reset_one_a: assert property (dev_reset_o |-> reset_pulse)
		else $error("device reset wider than one cycle");
	start_rise_a: assert property (op_start_o |-> tck_i)
		else $error("operation start away from a test clock rise");
	kind_set_a: assert property (op_start_o |=> op_kind_o != 2'h0)
		else $error("operation started without a kind");
	kind_hold_a: assert property ($changed(op_kind_o) |->
		op_start_o || $past(op_start_o))
		else $error("operation kind changed without a start");
	tdo_fall_a: assert property ($changed({tdo_o, tdo_oe_o}) |-> !tck_i)
		else $error("data output moved while test clock high");
	data_upd_a: assert property ($changed(cfg_data_o) |-> tck_i)
		else $error("config data moved away from update");
	tlr_hold_a: assert property (hi_cnt_reg == 3'h7 |-> tlr_o)
		else $error("mode select high did not reach reset");
	tlr_quiet_a: assert property (tlr_o |-> !tdo_oe_o && !op_start_o)
		else $error("activity while in reset state");
endmodule // tpp_top_monitor
bind tpp_top tpp_top_monitor u_mon (
	.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .tck_i(tck_i),
	.tms_i(tms_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
	.op_start_o(op_start_o), .op_kind_o(op_kind_o),
	.cfg_data_o(cfg_data_o), .dev_reset_o(dev_reset_o), .tlr_o(tlr_o));

/* bench/tpp_host_model.sv */
/* Test host model driving the test pins one clock at a time.
 * Assumes the bench calls step; the test clock rests low between calls. */
`timescale 1ns/100ps
module tpp_host_model (
	output reg  tck_o,
	output reg  tms_o,
	output reg  tdi_o,
	input  wire tdo_i,
	input  wire tdo_oe_i
);
	// Pins start low with the clock stopped
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b0;
		tdi_o = 1'b0;
	end
	// Present pins, sample the reply before the rise, then pulse
	task step(input bit m, input bit d, output logic o, output logic e);
		tms_o = m;
		tdi_o = d;
		#62.5;
		o = tdo_i;
		e = tdo_oe_i;
		tck_o = 1'b1;
		#62.5;
		tck_o = 1'b0;
	endtask
endmodule // tpp_host_model

/* bench/tpp_top_bench.sv */
/* Bench for tpp_top: a reference model of the controller is checked at
 * every test clock. Assumes tpp_host_model drives the pins. */
`timescale 1ns/100ps
`include "tpp_consts.vh"
module tpp_top_bench;
	localparam [31:0] ID = 32'h13579BDF; // Arbitrary identity value
	localparam [63:0] N0 = 64'h1BDDBBA146644311; // Next state, mode low
	localparam [63:0] N1 = 64'h2FEFCC0287855920; // Next state, mode high
	reg sys_clk_i = 1'b0;
	reg reset_n_i = 1'b0;
	wire tck, tms, tdi, tdo, oe, st_o, dr_o, tlr;
	wire [1:0] kind_o;
	wire [7:0] ins_o, adr_o;
	wire [31:0] dat_o;
	int bad_count = 0, checks_done = 0, seed = 32'h2279, t;
	int st = 0, ns, starts = 0, resets = 0, kind = 0, a_st = 0, a_rs = 0;
	bit [7:0] ir = 8'h16, instr = 8'h16, pend = 8'h00, adr = 8'h00;
	bit [7:0] byp[3] = '{8'hFF, 8'h00, 8'h1C};
	bit [7:0] dfr[7] = '{8'h2E, 8'h07, 8'h1A, 8'h29, 8'h03, 8'h28, 8'h0A};
	bit [31:0] dat = 32'h0;
	bit kn, kna = 1, knd = 1;
	bit sh[$], din[$];
	always #5 sys_clk_i = ~sys_clk_i;
	// Count the design's pulses
	always @(posedge sys_clk_i) begin
		if (st_o === 1'b1) a_st++;
		if (dr_o === 1'b1) a_rs++;
	end
	tpp_top #(.ID_VALUE(ID)) u_tpp_top (.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.tdo_o(tdo), .tdo_oe_o(oe), .op_start_o(st_o), .op_kind_o(kind_o),
		.op_instr_o(ins_o), .cfg_addr_o(adr_o), .cfg_data_o(dat_o),
		.dev_reset_o(dr_o), .tlr_o(tlr));
	tpp_host_model u_tpp_host_model (.tck_o(tck), .tms_o(tms),
		.tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(oe));
	// Kind of a deferred instruction, 0 when acted on at update
	function int okind(bit [7:0] c);
		case (c)
			8'h2E, 8'h07, 8'h1A: return 1;
			8'h29, 8'h03: return 2;
			8'h28, 8'h0A: return 3;
			default: return 0;
		endcase
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task load(input logic [31:0] v, input int w);
		sh = {};
		kn = 1;
		for (int j = 0; j < w; j++) sh.push_back(v[j]);
	endtask
	// One test clock through host and model
	task clk(input bit m, input bit d);
		logic o, e;
		bit sft;
		u_tpp_host_model.step(m, d, o, e);
		sft = st == 4'h4 || st == 4'hB;
		check(32'(e), 32'(sft));
		if (sft && kn) check(32'(o), 32'(sh[0]));
		ns = m ? N1[st*4 +: 4] : N0[st*4 +: 4];
		if (sft) begin
			void'(sh.pop_front());
			sh.push_back(d);
			din.push_back(d);
		end
		case (st)
			4'h3: begin
				load(ir == 8'h16 ? ID : ir == 8'h2B ? {24'h0, adr} :
					ir == 8'h2D ? dat : 32'h0,
					ir == 8'h16 || ir == 8'h2D ? 32 : ir == 8'h2B ? 8 : 1);
				kn = (ir != 8'h2B || kna) && (ir != 8'h2D || knd);
				din = {};
			end
			4'hA: load(32'h16, 8);
			4'hF: begin
				for (int j = 0; j < 8; j++) ir[j] = sh[j];
				if (ir == 8'h22) resets++;
				pend = okind(ir) != 0 ? ir : 8'h00;
			end
			4'h8: begin
				if (ir == 8'h2B) kna = din.size() >= 8;
				if (ir == 8'h2D) knd = din.size() >= 32;
				for (int j = 0; j < 32; j++) begin
					if (ir == 8'h2B && j < 8) adr[j] = din[din.size() - 8 + j];
					if (ir == 8'h2D) dat[j] = din[din.size() - 32 + j];
				end
			end
			default: ;
		endcase
		if (ns == 1 && (st == 8 || st == 15) && pend != 8'h00) begin
			starts++;
			kind = okind(pend);
			instr = pend;
			pend = 8'h00;
		end
		if (ns == 0) begin
			pend = 8'h00;
			ir = 8'h16;
		end
		st = ns;
	endtask
	// Scan from idle with a pause half way, then update
	task scan(input bit isir, input int n, input logic [31:0] v, input bit fin);
		clk(1, 0);
		if (isir) clk(1, 0);
		clk(0, 0);
		clk(0, 0);
		for (int i = 0; i < n; i++) begin
			clk(i == n - 1 || i == n / 2, v[i]);
			if (i == n / 2 && i != n - 1)
				for (int k = 0; k < 4; k++) clk(k == 2, 0);
		end
		clk(1, 0);
		clk(fin, 0);
	endtask
	task sum(input int n);
		check(a_st, starts);
		check(a_rs, resets);
		check({30'h0, kind_o}, kind);
		check({24'h0, ins_o}, {24'h0, instr});
		if (kna) check({24'h0, adr_o}, {24'h0, adr});
		if (knd) check(dat_o, dat);
		$display("test %0d done", n);
	endtask
	task results;
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		clk(0, 0);
		scan(0, 32, $random(seed), 0);
		sum(1);
		for (t = 0; t < 3; t++) begin
			scan(1, 8, byp[t], 0);
			scan(0, 32, $random(seed), 0);
		end
		sum(2);
		scan(1, 8, 8'h16, 0);
		scan(0, 32, $random(seed), 0);
		scan(1, 8, 8'h2B, 0);
		scan(0, 8, $random(seed), 0);
		scan(1, 8, 8'h2D, 0);
		scan(0, 32, $random(seed), 0);
		sum(3);
		for (t = 0; t < 7; t++) scan(1, 8, dfr[t], 0);
		scan(1, 8, 8'h22, 0);
		sum(4);
		scan(1, 8, 8'h2E, 1);
		for (t = 0; t < 3; t++) clk(t < 2, 0);
		sum(5);
		for (t = 0; t < 300; t++) clk(1'($random(seed)), 1'($random(seed)));
		for (t = 0; t < 6; t++) clk(t < 5, 0);
		sum(6);
		results;
	end
	// Watchdog
	initial begin
		#300000;
		bad_count++;
		results;
	end
endmodule // tpp_top_bench
